//--- verilog/cs_cfg.svh
// constants of the card specific data link: field positions, fixed values, timing
`ifndef CS_CFG_SVH
`define CS_CFG_SVH

`define CS_WIDTH          128
`define CS_STRUCT_HI      127
`define CS_STRUCT_LO      126
`define CS_STRUCT_VAL     2'h2
`define CS_SPEC_HI        125
`define CS_SPEC_LO        122
`define CS_SPEC_VAL       4'h3
`define CS_ASYNC_HI       119
`define CS_ASYNC_LO       112
`define CS_ASYNC_VAL      8'h0E
`define CS_CLKD_HI        111
`define CS_CLKD_LO        104
`define CS_CLKD_VAL       8'h01
`define CS_RATE_HI        103
`define CS_RATE_LO        96
`define CS_RATE_VAL       8'h2A
`define CS_CCC_HI         95
`define CS_CCC_LO         84
`define CS_CCC_VAL        12'h0FF
`define CS_RBL_HI         83
`define CS_RBL_LO         80
`define CS_RBL_VAL        4'h9
`define CS_RBL_MAX        4'hB
`define CS_PART_BIT       79
`define CS_PART_VAL       1'h1
`define CS_WMIS_BIT       78
`define CS_WMIS_VAL       1'h0
`define CS_RMIS_BIT       77
`define CS_RMIS_VAL       1'h0
`define CS_DSR_BIT        76
`define CS_DSR_VAL        1'h0
`define CS_SIZE_HI        73
`define CS_SIZE_LO        62
`define CS_SIZE_VAL       12'h7A7
`define CS_MULT_HI        49
`define CS_MULT_LO        47
`define CS_MULT_VAL       3'h2
`define CS_ONE_BIT        0
`define CS_CLKD_UNIT      100
`define CS_CLK_PERIOD_NS  100
`define CS_LINK_HALF      8
`define CS_REG_CTRL       3'h0
`define CS_REG_WORD0      3'h1
`define CS_REG_WORD1      3'h2
`define CS_REG_WORD2      3'h3
`define CS_REG_WORD3      3'h4
`define CS_REG_BLOCKS     3'h5
`define CS_REG_DELAY      3'h6
`define CS_REG_BLKLEN     3'h7

`endif

//--- verilog/cs_pkg.sv
// types of the host end of the card specific data link
package cs_pkg;
    typedef enum logic [1:0] {
        CS_H_IDLE,
        CS_H_LOW,
        CS_H_HIGH,
        CS_H_FIN
    } cs_host_state_type;
endpackage : cs_pkg

//--- verilog/cs_link_if.sv
// serial link between card and host
`timescale 1ns/1ns
interface cs_link_if;
    logic lclk;
    logic req;
    logic dat;
    modport card (input lclk, input req, output dat);
    modport host (output lclk, output req, input dat);
endinterface : cs_link_if

//--- verilog/cs_card.sv
// card end: holds the card specific data register and shifts it out
`timescale 1ns/1ns
`include "cs_cfg.svh"
module cs_card #(
    parameter logic [2:0] SIZE_MULT = `CS_MULT_VAL
) (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    cs_link_if.card   link
);
    logic [`CS_WIDTH-1:0] card_specific_data;
    logic [1:0]           lclk_s_q;
    logic [1:0]           req_s_q;
    logic                 lclk_d1_q;
    logic                 req_d1_q;
    logic [`CS_WIDTH-1:0] shift_q;

    always_comb begin
        card_specific_data = '0;
        card_specific_data[`CS_STRUCT_HI:`CS_STRUCT_LO] = `CS_STRUCT_VAL;
        card_specific_data[`CS_SPEC_HI:`CS_SPEC_LO]     = `CS_SPEC_VAL;
        card_specific_data[`CS_ASYNC_HI:`CS_ASYNC_LO]   = `CS_ASYNC_VAL;
        card_specific_data[`CS_CLKD_HI:`CS_CLKD_LO]     = `CS_CLKD_VAL;
        card_specific_data[`CS_RATE_HI:`CS_RATE_LO]     = `CS_RATE_VAL;
        card_specific_data[`CS_CCC_HI:`CS_CCC_LO]       = `CS_CCC_VAL;
        card_specific_data[`CS_RBL_HI:`CS_RBL_LO]       = `CS_RBL_VAL;
        card_specific_data[`CS_PART_BIT]                = `CS_PART_VAL;
        card_specific_data[`CS_WMIS_BIT]                = `CS_WMIS_VAL;
        card_specific_data[`CS_RMIS_BIT]                = `CS_RMIS_VAL;
        card_specific_data[`CS_DSR_BIT]                 = `CS_DSR_VAL;
        card_specific_data[`CS_SIZE_HI:`CS_SIZE_LO]     = `CS_SIZE_VAL;
        card_specific_data[`CS_MULT_HI:`CS_MULT_LO]     = SIZE_MULT;
        card_specific_data[`CS_ONE_BIT]                 = 1'b1;
    end

    // two-flop synchronisers for the host-made clock and request
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lclk_s_q <= 2'h0;
            req_s_q  <= 2'h0;
        end else begin
            lclk_s_q <= {lclk_s_q[0], link.lclk};
            req_s_q  <= {req_s_q[0], link.req};
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lclk_d1_q <= 1'b0;
            req_d1_q  <= 1'b0;
        end else begin
            lclk_d1_q <= lclk_s_q[1];
            req_d1_q  <= req_s_q[1];
        end
    end

    // load on request rise, shift out msb first on each link clock rise
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_q <= '0;
        end else if (req_s_q[1] && !req_d1_q) begin
            shift_q <= card_specific_data;
        end else if (!req_s_q[1]) begin
            shift_q <= '0;
        end else if (lclk_s_q[1] && !lclk_d1_q) begin
            shift_q <= {shift_q[`CS_WIDTH-2:0], 1'b0};
        end
    end

    assign link.dat = shift_q[`CS_WIDTH-1];
endmodule : cs_card

//--- verilog/cs_host.sv
// host end: reads the card specific data over the link and decodes it
`timescale 1ns/1ns
`include "cs_cfg.svh"
module cs_host #(
    parameter int HALF = `CS_LINK_HALF
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [2:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    cs_link_if.host          link
);
    localparam int LINK_PERIOD_NS = 2 * HALF * `CS_CLK_PERIOD_NS;

    cs_pkg::cs_host_state_type state_q;
    logic [1:0]           dat_s_q;
    logic [7:0]           cnt_q;
    logic [7:0]           bits_q;
    logic [`CS_WIDTH-1:0] data_q;
    logic                 done_q;
    logic                 ack_q;
    logic                 start;
    logic [31:0]          rdata_d;
    logic [31:0]          rdata_q;
    logic [7:0]           async_code;
    logic [7:0]           mant10;
    logic [31:0]          pow_ns;
    logic [31:0]          delay_tenth_ns;
    logic [31:0]          block_count;
    logic [31:0]          block_len;
    logic                 field_err;

    // a start write takes effect at the edge where waitrequest is low
    assign start = avs_write_i && ack_q && avs_address_i == `CS_REG_CTRL
                   && avs_writedata_i[0] && state_q == cs_pkg::CS_H_IDLE;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dat_s_q <= 2'h0;
        end else begin
            dat_s_q <= {dat_s_q[0], link.dat};
        end
    end

    // link sequencer: own divider makes the link clock, sample just before rise
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= cs_pkg::CS_H_IDLE;
            cnt_q   <= 8'h00;
            bits_q  <= 8'h00;
            data_q  <= '0;
        end else begin
            case (state_q)
                cs_pkg::CS_H_IDLE: begin
                    if (start) begin
                        state_q <= cs_pkg::CS_H_LOW;
                        cnt_q   <= 8'h00;
                        bits_q  <= 8'h00;
                    end
                end
                cs_pkg::CS_H_LOW: begin
                    if (cnt_q == 8'(HALF - 1)) begin
                        data_q  <= {data_q[`CS_WIDTH-2:0], dat_s_q[1]};
                        cnt_q   <= 8'h00;
                        state_q <= cs_pkg::CS_H_HIGH;
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                cs_pkg::CS_H_HIGH: begin
                    if (cnt_q == 8'(HALF - 1)) begin
                        cnt_q  <= 8'h00;
                        bits_q <= bits_q + 8'h01;
                        if (bits_q == 8'(`CS_WIDTH - 1)) begin
                            state_q <= cs_pkg::CS_H_FIN;
                        end else begin
                            state_q <= cs_pkg::CS_H_LOW;
                        end
                    end else begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                cs_pkg::CS_H_FIN: begin
                    state_q <= cs_pkg::CS_H_IDLE;
                end
                default: begin
                    state_q <= cs_pkg::CS_H_IDLE;
                end
            endcase
        end
    end

    assign link.lclk = (state_q == cs_pkg::CS_H_HIGH);
    assign link.req  = (state_q == cs_pkg::CS_H_LOW) || (state_q == cs_pkg::CS_H_HIGH);

    // done flag: set at end of read wins over a clear by a new start
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_q <= 1'b0;
        end else if (state_q == cs_pkg::CS_H_FIN) begin
            done_q <= 1'b1;
        end else if (start) begin
            done_q <= 1'b0;
        end
    end

    // decode of the received fields
    assign async_code = data_q[`CS_ASYNC_HI:`CS_ASYNC_LO];

    always_comb begin
        case (async_code[6:3])
            4'h1:    mant10 = 8'h0A;
            4'h2:    mant10 = 8'h0C;
            4'h3:    mant10 = 8'h0D;
            4'h4:    mant10 = 8'h0F;
            4'h5:    mant10 = 8'h14;
            4'h6:    mant10 = 8'h19;
            4'h7:    mant10 = 8'h1E;
            4'h8:    mant10 = 8'h23;
            4'h9:    mant10 = 8'h28;
            4'hA:    mant10 = 8'h2D;
            4'hB:    mant10 = 8'h32;
            4'hC:    mant10 = 8'h37;
            4'hD:    mant10 = 8'h3C;
            4'hE:    mant10 = 8'h46;
            4'hF:    mant10 = 8'h50;
            default: mant10 = 8'h00;
        endcase
        case (async_code[2:0])
            3'h0:    pow_ns = 32'h0000_0001;
            3'h1:    pow_ns = 32'h0000_000A;
            3'h2:    pow_ns = 32'h0000_0064;
            3'h3:    pow_ns = 32'h0000_03E8;
            3'h4:    pow_ns = 32'h0000_2710;
            3'h5:    pow_ns = 32'h0001_86A0;
            3'h6:    pow_ns = 32'h000F_4240;
            default: pow_ns = 32'h0098_9680;
        endcase
    end

    // total access delay in tenths of ns at the link clock actually used
    assign delay_tenth_ns = 32'(mant10) * pow_ns
        + 32'(data_q[`CS_CLKD_HI:`CS_CLKD_LO]) * 32'(`CS_CLKD_UNIT * LINK_PERIOD_NS * 10);

    assign block_count = (32'(data_q[`CS_SIZE_HI:`CS_SIZE_LO]) + 32'h1)
        << (32'(data_q[`CS_MULT_HI:`CS_MULT_LO]) + 32'h2);
    assign block_len = 32'h1 << data_q[`CS_RBL_HI:`CS_RBL_LO];

    // reserved codes seen in the received fields
    assign field_err = async_code[7] || async_code[6:3] == 4'h0
        || data_q[`CS_RATE_HI] || data_q[`CS_RATE_HI-1:`CS_RATE_LO+3] == 4'h0
        || data_q[`CS_RATE_LO+2]
        || data_q[`CS_RBL_HI:`CS_RBL_LO] > `CS_RBL_MAX;

    // avalon slave: one wait cycle then answer
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

    always_comb begin
        case (avs_address_i)
            `CS_REG_CTRL:   rdata_d = {29'h0, field_err, done_q,
                                       state_q != cs_pkg::CS_H_IDLE};
            `CS_REG_WORD0:  rdata_d = data_q[127:96];
            `CS_REG_WORD1:  rdata_d = data_q[95:64];
            `CS_REG_WORD2:  rdata_d = data_q[63:32];
            `CS_REG_WORD3:  rdata_d = data_q[31:0];
            `CS_REG_BLOCKS: rdata_d = block_count;
            `CS_REG_DELAY:  rdata_d = delay_tenth_ns;
            `CS_REG_BLKLEN: rdata_d = block_len;
            default:        rdata_d = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0;
        end else if (avs_read_i && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata_o = rdata_q;
endmodule : cs_host

//--- verilog/cs_unused_placeholder_never.sv
// intentionally empty module-free file
`timescale 1ns/1ns

//--- testbench/cs_link_props.sv
// checker for the serial link between card and host
`timescale 1ns/1ns
module cs_link_props (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    input  wire logic lclk_i,
    input  wire logic req_i,
    input  wire logic dat_i
);
    logic       lclk_prev_q;
    logic [7:0] rise_cnt_q;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lclk_prev_q <= 1'b0;
        end else begin
            lclk_prev_q <= lclk_i;
        end
    end

    // counts link clock rises within one frame
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rise_cnt_q <= 8'h00;
        end else if (!req_i) begin
            rise_cnt_q <= 8'h00;
        end else if (lclk_i && !lclk_prev_q) begin
            rise_cnt_q <= rise_cnt_q + 8'h01;
        end
    end

    idle_clk_low_a: assert property (!req_i |-> !lclk_i)
        else $error("link clock runs outside a frame");
    clk_high_len_a: assert property ($rose(lclk_i) |-> lclk_i[*8] ##1 !lclk_i)
        else $error("link clock high phase has wrong length");
    clk_low_len_a: assert property ($fell(lclk_i) |-> !lclk_i[*8])
        else $error("link clock low phase too short");
    frame_start_a: assert property ($rose(req_i) |-> !lclk_i[*8] ##1 lclk_i)
        else $error("frame does not open with a full low phase");
    struct_code_a: assert property ($rose(req_i) |-> ##7 dat_i ##16 !dat_i)
        else $error("structure code on the wire is wrong");
    spec_code_a: assert property ($rose(req_i) |-> ##39 !dat_i ##16 !dat_i
        ##16 dat_i ##16 dat_i)
        else $error("spec version code on the wire is wrong");
    async_code_a: assert property ($rose(req_i) |-> ##135 !dat_i
        ##16 !dat_i ##16 !dat_i ##16 !dat_i ##16 dat_i ##16 dat_i ##16 dat_i ##16 !dat_i)
        else $error("async access time code on the wire is wrong");
    frame_len_a: assert property ($fell(req_i) |-> rise_cnt_q == 8'h80)
        else $error("frame did not carry 128 link clock periods");
endmodule : cs_link_props

//--- testbench/card_specific_data_fields_tb.sv
// bench: host reads the card register over the link, software checks the results
`timescale 1ns/1ns
module card_specific_data_fields_tb;
    logic         ref_clk_i;
    logic         nrst_i;
    logic [2:0]   avs_address_i;
    logic         avs_read_i;
    logic         avs_write_i;
    logic [31:0]  avs_writedata_i;
    logic [31:0]  avs_readdata_o;
    logic         avs_waitrequest_o;
    logic [127:0] exp_csd;
    logic [31:0]  rd;
    int           err_total;
    int           samples_checked;

    cs_link_if cs_link_if_i ();
    cs_card #(.SIZE_MULT(3'h2)) cs_card_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(cs_link_if_i));
    cs_host #(.HALF(8)) cs_host_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .link(cs_link_if_i));
    cs_link_props cs_link_props_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .lclk_i(cs_link_if_i.lclk),
        .req_i(cs_link_if_i.req), .dat_i(cs_link_if_i.dat));

    initial ref_clk_i = 1'b0;
    always #50 ref_clk_i = ~ref_clk_i;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= 1'b1;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : av_wr

    task automatic av_rd(input logic [2:0] a, output logic [31:0] d);
        avs_address_i <= a;
        avs_read_i    <= 1'b1;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask : av_rd

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        give_verdict();
    end

    initial begin
        err_total       = 0;
        samples_checked = 0;
        nrst_i          = 1'b0;
        avs_address_i   = 3'h0;
        avs_read_i      = 1'b0;
        avs_write_i     = 1'b0;
        avs_writedata_i = 32'h0000_0000;
        exp_csd = {2'b10, 4'b0011, 2'b00, 8'h0E, 8'h01, 8'h2A, 12'h0FF, 4'h9, 1'b1, 1'b0,
                   1'b0, 1'b0, 2'b00, 12'h7A7, 12'h000, 3'h2, 46'h0, 1'b1};
        repeat (4) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        for (int run = 0; run < 2; run++) begin
            av_wr(3'h0, 32'h0000_0001);
            av_rd(3'h0, rd);
            chk("busy", 32'h0000_0001, rd & 32'h0000_0001);
            av_wr(3'h0, 32'h0000_0001);
            av_wr(3'h1, 32'hFFFF_FFFF);
            for (int i = 0; i < 1000 && rd[1] !== 1'b1; i++) av_rd(3'h0, rd);
            chk("status", 32'h0000_0002, rd);
            for (int w = 0; w < 4; w++) begin
                av_rd(3'(w + 1), rd);
                chk("csd word", exp_csd[127 - 32 * w -: 32], rd);
            end
            av_rd(3'h5, rd);
            chk("block count", (32'h0000_07A7 + 32'h1) << (2 + 2), rd);
            av_rd(3'h6, rd);
            chk("access delay", 32'd10000000 + 32'd1 * 100 * 1600 * 10, rd);
            av_rd(3'h7, rd);
            chk("block length", 32'h0000_0001 << 9, rd);
        end
        give_verdict();
    end
endmodule : card_specific_data_fields_tb
